/* File: bench/vcst_host_bench.sv */
// Self-checking bench for the video memory strobe controller
`timescale 1ns/10ps
module vcst_host_bench;
    import vcst_pkg::*;
    logic          clock, rst_n, hwrite, hreadyout, dq_oe, hresp;
    logic          sclk, soe_n, half, ready_s;
    logic [31:0]   haddr, hwdata, hrdata, rdata_s, s;
    logic [1:0]    htrans;
    logic [15:0]   dq_out, dq_wire, sq;
    vcst_pins_type pins;
    int            fail_count = 0;
    int            cmp_count  = 0;

    assign dq_wire = dq_oe ? dq_out : {16{clock}} ^ 16'h5A5A;

    vcst_host vcst_host_i (.CLOCK(clock), .RST_N(rst_n), .HSEL(1'b1),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
        .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout),
        .HRDATA(hrdata), .HRESP(hresp), .DRAM_PINS(pins),
        .DATA_IO_PINS_IN(dq_wire), .DATA_IO_PINS_OUT(dq_out),
        .DATA_IO_PINS_OE(dq_oe), .SERIAL_SHIFT_CLOCK(sclk),
        .SERIAL_OUTPUT_ENABLE_N(soe_n), .SERIAL_DATA_IN(sq),
        .SERIAL_HALF_INDICATOR(half));
    vcst_vram_model vcst_vram_model_i (.pins(pins), .dq(dq_wire),
        .sclk(sclk), .soe_n(soe_n), .sq(sq), .half(half));

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(negedge clock)
    begin
        ready_s <= hreadyout;
        rdata_s <= hrdata;
    end

    task automatic test_done();
        if (fail_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge clock);
        while (ready_s !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                check("bus wait", 32'h0, 32'h1);
                test_done();
            end
            @(posedge clock);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = rdata_s;
        check("bus response", 32'h0, {31'h0, hresp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic idle();
        int n;
        n = 0;
        bus(1'b0, REG_STATUS, 32'h0, s);
        while (s[ST_BUSY_BIT] !== 1'b0 || s[ST_SBUSY_BIT] !== 1'b0)
        begin
            n++;
            if (n > 2000)
            begin
                check("idle wait", 32'h0, 32'h1);
                test_done();
            end
            bus(1'b0, REG_STATUS, 32'h0, s);
        end
    endtask
    task automatic op(input logic [2:0] c, input logic [8:0] r, cl,
                      input logic [1:0] en);
        wr(REG_ROW, {23'h0, r});
        wr(REG_COL, {23'h0, cl});
        wr(REG_CMD, {27'h0, en, c});
        idle();
    endtask
    task automatic err(input logic e);
        check("error flag", {31'h0, e}, {31'h0, s[ST_ERR_BIT]});
        wr(REG_STATUS, 32'h10);
    endtask
    task automatic ser(input logic [8:0] n, input logic [7:0] p,
                       input logic oe);
        wr(REG_SERIAL, {15'h0, oe, 7'h0, n});
        idle();
        repeat (4) @(posedge clock);
        bus(1'b0, REG_STATUS, 32'h0, s);
        check("output enable", {31'h0, !oe}, {31'h0, soe_n});
        check("pointer", {24'h0, p}, {24'h0, vcst_vram_model_i.ptr});
        check("half flag", {31'h0, p[7]}, {31'h0, s[ST_HALF_BIT]});
    endtask

    task automatic sc_reset();
        check("idle pins", {17'h0, PINS_IDLE}, {17'h0, pins});
        check("color", {16'h0, 16'hxxxx}, {16'h0, vcst_vram_model_i.color});
        bus(1'b0, 8'h40, 32'h0, s);
        check("unmapped read", 32'h0, s);
        op(OP_SPLIT, 9'h0A5, 9'h010, 2'b11);
        err(1'b1);
    endtask
    task automatic sc_color();
        wr(REG_COLOR, 32'h1234);
        op(OP_COLOR, 9'h011, 9'h000, 2'b11);
        check("color", 32'h1234, {16'h0, vcst_vram_model_i.color});
        wr(REG_COLOR, 32'hABCD);
        op(OP_COLOR, 9'h011, 9'h000, 2'b01);
        check("color", 32'h12CD, {16'h0, vcst_vram_model_i.color});
    endtask
    task automatic sc_full();
        op(OP_FULL, 9'h0A5, 9'h1FD, 2'b11);
        err(1'b0);
        check("half flag", 32'h1, {31'h0, s[ST_HALF_BIT]});
        ser(9'd5, 8'h02, 1'b1);
        bus(1'b0, REG_SDATA, 32'h0, s);
        check("serial word", 32'h1, {31'h0, s[15:0] === 16'h4B00
              || s[15:0] === 16'h4B01});
        check("color", 32'h12CD, {16'h0, vcst_vram_model_i.color});
    endtask
    task automatic sc_split();
        op(OP_SPLIT, 9'h0A5, 9'h07F, 2'b11);
        err(1'b1);
        op(OP_SPLIT, 9'h0A5, 9'h010, 2'b11);
        err(1'b0);
        ser(9'd126, 8'h90, 1'b1);
        ser(9'd112, 8'h00, 1'b0);
    endtask
    task automatic sc_stop();
        op(OP_STOP, 9'h030, 9'h000, 2'b11);
        check("stop code", 32'h7, {27'h0, s[11:8], s[ST_STOP_BIT]});
        op(OP_SPLIT, 9'h0A5, 9'h03F, 2'b11);
        err(1'b1);
        op(OP_OPTRST, 9'h000, 9'h000, 2'b11);
        check("stop mode", 32'h0, {31'h0, s[ST_STOP_BIT]});
        check("model stop", 32'h0, {31'h0, vcst_vram_model_i.stop_mode});
    endtask

    initial
    begin
        rst_n  = 1'b0;
        haddr  = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        sc_reset();
        sc_color();
        sc_full();
        sc_split();
        sc_stop();
        test_done();
    end
endmodule

/* File: bench/vcst_vram_model.sv */
// Behavioural video memory on the far side of the strobe controller
`timescale 1ns/10ps
module vcst_vram_model
    import vcst_pkg::*;
(
    // Strobes and data pins
    input  wire vcst_pkg::vcst_pins_type pins,
    input  wire logic [15:0]             dq,
    // Serial port
    input  wire logic                    sclk,
    input  wire logic                    soe_n,
    output logic [15:0]                  sq,
    output logic                         half
);
    import vcst_pkg::*;
    logic [15:0] color;
    logic [7:0]  ptr         = 8'h00;
    logic [7:0]  next_tap;
    logic        tap_pending = 1'b0;
    logic        split_mode  = 1'b0;
    logic        stop_mode   = 1'b0;
    logic [3:0]  stop_code;
    logic [8:0]  row;
    logic        row_half;
    logic [1:0]  kind;
    logic [8:0]  col;

    assign half = ptr[7];
    assign col  = stop_mode ? {pins.addr[7], pins.addr[8], pins.addr[6:0]}
                            : pins.addr;
    initial sq = 16'h0000;

    // Row strobe fall picks the cycle kind
    always @(negedge pins.row_strobe_n)
    begin
        kind = 2'd0;
        if (!pins.col_strobe_n)
        begin
            stop_mode = pins.special_function_sel
                        && !pins.low_byte_write_enable_n;
            stop_code = pins.addr[7:4];
        end
        else if (!pins.transfer_output_gate_n
                 && pins.low_byte_write_enable_n
                 && pins.high_byte_write_enable_n)
            kind = pins.special_function_sel ? 2'd3 : 2'd2;
        else if (pins.special_function_sel)
            kind = 2'd1;
        row = pins.addr;
    end

    // Column strobe fall completes the cycle
    always @(negedge pins.col_strobe_n)
    begin
        if (pins.row_strobe_n)
            kind = 2'd0;
        if (kind == 2'd1 && pins.special_function_sel)
        begin
            if (!pins.low_byte_write_enable_n)
                color[7:0] = dq[7:0];
            if (!pins.high_byte_write_enable_n)
                color[15:8] = dq[15:8];
        end
        else if (kind == 2'd2)
        begin
            {row_half, ptr} <= col;
            split_mode      <= 1'b0;
            tap_pending     <= 1'b0;
        end
        else if (kind == 2'd3)
        begin
            next_tap    <= {~ptr[7], col[6:0]};
            tap_pending <= 1'b1;
            split_mode  <= 1'b1;
        end
    end

    // Serial access; released outputs toggle
    always @(posedge sclk)
    begin
        sq <= soe_n ? ~sq : {row[6:0], row_half, ptr};
        if (split_mode && ptr[6:0] == 7'h7F && tap_pending)
        begin
            ptr         <= next_tap;
            tap_pending <= 1'b0;
        end
        else
            ptr <= ptr + 8'h01;
    end
endmodule

/* File: src/vcst_host.sv */
// Host controller driving the video memory strobes and serial port
`timescale 1ns/10ps

// Behaviour
// R1 - Color load uses write timing with select high at both strobe falls
// R2 - Device latches all sixteen data pins at later of column or enable fall
// R3 - With one byte enable low, only that color byte loads
// R4 - Color register holds until the next color load or power loss
// R5 - Block write masks: zero bits leave columns or data bits unwritten
// R6 - Block write ignores column bits 0 to 2 and picks block
// R7 - Transfer starts with gate low and enables high at row fall
// R8 - Transfer copies half a row, 256 words, into serial store
// R9 - Full transfer: row bits pick row, A8 half, A0-A7 tap
// R10 - Full transfer form chosen by where gate trailing edge falls
// R11 - Split transfers reload one store half while other shifts out
// R12 - Split: select high, gate low; A7 ignored, A0-A6 pick tap
// R13 - Split taps 127, 255 and stop points are not allowed
// R14 - A full transfer must come before the first split transfer
// R15 - Half indicator low for lower half, high for upper half
// R16 - Half indicator follows tap after full transfer and at crossings
// R17 - Serial reads run independently except during transfers (the controller halts the shift clock during every strobe cycle)
// R18 - Output enable gates outputs; every shift clock edge advances pointer (the model advances it on rising edges only)
// R19 - After full transfer pointer runs to 255 then wraps to 0
// R20 - Split pointer reaches half top, then new tap or next half
// R21 - Stop-point mode splits store into partitions ending in stop points
// R22 - Stop set: column strobe, enables low, select high at row fall
// R23 - In stop-point mode column bits seven and eight are swapped
// R24 - Option reset cycle ends stop-point mode; avoid it when needed
// R25 - Color register is undefined after power-up until first load
module vcst_host
#(
    parameter int COUNT_W = 9
)
(
    // Clock and reset
    input  wire logic                   CLOCK,
    input  wire logic                   RST_N,
    // AHB-Lite slave
    input  wire logic                   HSEL,
    input  wire logic [31:0]            HADDR,
    input  wire logic [1:0]             HTRANS,
    input  wire logic                   HWRITE,
    input  wire logic [2:0]             HSIZE,
    input  wire logic [31:0]            HWDATA,
    input  wire logic                   HREADY,
    output logic                        HREADYOUT,
    output logic [31:0]                 HRDATA,
    output logic                        HRESP,
    // Memory strobes and control
    output vcst_pkg::vcst_pins_type     DRAM_PINS,
    // Data pins
    input  wire logic [15:0]            DATA_IO_PINS_IN,
    output logic [15:0]                 DATA_IO_PINS_OUT,
    output logic                        DATA_IO_PINS_OE,
    // Serial port
    output logic                        SERIAL_SHIFT_CLOCK,
    output logic                        SERIAL_OUTPUT_ENABLE_N,
    input  wire logic [15:0]            SERIAL_DATA_IN,
    input  wire logic                   SERIAL_HALF_INDICATOR
);
    import vcst_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE, S_SETUP, S_RAS, S_COL, S_CAS, S_TRG, S_END, S_PRE
    } vcst_state_type;

    vcst_state_type      state;
    vcst_state_type      next_state;
    vcst_pins_type       next_pins;
    logic [2:0]          op;
    logic                low_en;
    logic                high_en;
    logic [8:0]          row;
    logic [8:0]          col;
    logic [15:0]         color;
    logic [2:0]          step;
    logic                full_done;
    logic                stop_mode;
    logic [3:0]          stop_code;
    logic                err;
    logic                dq_oe;
    logic [15:0]         dq_out;
    logic [COUNT_W-1:0]  ser_count;
    logic                ser_oe;
    logic [3:0]          div;
    logic                sc;
    logic [15:0]         sdata;
    logic [15:0]         sq_meta;
    logic [15:0]         sq_sync;
    logic                half_meta;
    logic                half_sync;
    logic                wr_pend;
    logic [7:0]          wr_addr;
    logic [7:0]          rd_addr;

    // Bus decode
    wire        bus_go    = HSEL && HREADY && HTRANS[1];
    wire        wr_cmd    = wr_pend && (wr_addr == REG_CMD);
    wire [2:0]  new_op    = HWDATA[CMD_OP_LSB +: 3];
    wire        is_xfer   = (op == OP_FULL) || (op == OP_SPLIT);
    wire        is_cbr    = (op == OP_STOP) || (op == OP_OPTRST);
    wire [6:0]  stop_mask = {stop_code[2:0], 4'hF};
    wire        bad_tap   = (col[6:0] == TAP_LAST) ||
                            (stop_mode &&
                             ((col[6:0] & stop_mask) == stop_mask));
    wire        op_valid  = (new_op != OP_NONE) && (new_op <= OP_OPTRST);
    wire        busy      = (state != S_IDLE);
    wire        refuse    = busy || !op_valid ||
                            ((new_op == OP_SPLIT) && (!full_done || bad_tap));
    wire        cmd_go    = wr_cmd && !refuse;
    wire        step_done = (state == S_PRE) ?
                            (step == 3'(T_PRE_CYC - 1)) :
                            (step == 3'(T_STEP_CYC - 1));
    wire        ser_run   = (state == S_IDLE) &&
                            ((ser_count != '0) || (div != 4'h0));
    wire        sc_rise   = ser_run && (div == 4'(SER_HALF - 1));
    wire        ends      = (state == S_END) && step_done;

    function automatic vcst_pins_type strobe(input vcst_state_type s);
        vcst_pins_type p;
        p = PINS_IDLE;
        if (s == S_SETUP || s == S_RAS || s == S_COL || s == S_CAS ||
            s == S_TRG)
        begin
            p.addr = row;
            p.special_function_sel = (op == OP_COLOR) || (op == OP_SPLIT)
                                     || (op == OP_STOP);        // R1 R7 R22
            p.transfer_output_gate_n = !is_xfer;                // R7
            p.col_strobe_n = !is_cbr;                           // R22 R24
            p.low_byte_write_enable_n = !(op == OP_STOP);       // R22
            p.high_byte_write_enable_n = !(op == OP_STOP);
            p.row_strobe_n = (s == S_SETUP);
        end
        if (s == S_COL || s == S_CAS || s == S_TRG)
        begin
            p.addr = col;
            p.special_function_sel = (op == OP_COLOR);          // R1
            p.low_byte_write_enable_n = !((op == OP_COLOR) && low_en);
            p.high_byte_write_enable_n = !((op == OP_COLOR) && high_en);
            p.col_strobe_n = (s == S_COL);
        end
        if (s == S_TRG)
            p.transfer_output_gate_n = 1'b1;                    // R10
        return p;
    endfunction

    always_comb
        next_pins = strobe(state);

    always_comb
    begin
        next_state = state;
        case (state)
            S_IDLE:  if (cmd_go) next_state = S_SETUP;
            S_SETUP: if (step_done) next_state = S_RAS;
            S_RAS:   if (step_done) next_state = is_cbr ? S_END : S_COL;
            S_COL:   if (step_done) next_state = S_CAS;
            S_CAS:   if (step_done) next_state = S_TRG;
            S_TRG:   if (step_done) next_state = S_END;
            S_END:   if (step_done) next_state = S_PRE;
            S_PRE:   if (step_done) next_state = S_IDLE;
            default: next_state = S_IDLE;
        endcase
    end

    // Sequencer
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state <= S_IDLE;
            step <= 3'h0;
            DRAM_PINS <= PINS_IDLE;
        end
        else
        begin
            state <= next_state;
            step <= (next_state != state) ? 3'h0 : step + 3'h1;
            DRAM_PINS <= next_pins;
        end
    end

    // Color data drive during the column phase of a color load
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            dq_oe <= 1'b0;
            dq_out <= 16'h0000;
        end
        else
        begin
            dq_oe <= (op == OP_COLOR) && (next_state == S_COL ||
                     next_state == S_CAS || next_state == S_TRG);  // R2
            dq_out <= color;
        end
    end

    assign DATA_IO_PINS_OE  = dq_oe;
    assign DATA_IO_PINS_OUT = dq_out;

    // Mode flags
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            full_done <= 1'b0;
            stop_mode <= 1'b0;
            stop_code <= 4'h0;
        end
        else if (ends)
        begin
            if (op == OP_FULL)
                full_done <= 1'b1;                              // R14
            if (op == OP_STOP)
            begin
                stop_mode <= 1'b1;                              // R21
                stop_code <= row[7:4];
            end
            if (op == OP_OPTRST)
                stop_mode <= 1'b0;                              // R24
        end
    end

    // Serial shift clock divider, halted during strobe cycles
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            div <= 4'h0;
            sc <= 1'b0;
            sdata <= 16'h0000;
        end
        else
        begin
            div <= !ser_run ? 4'h0 :
                   (div == 4'(SER_DIV - 1)) ? 4'h0 : div + 4'h1;
            sc <= sc_rise ||
                  (ser_run && sc && (div != 4'(SER_DIV - 1)));  // R17
            if (sc_rise)
                sdata <= sq_sync;                               // R18
        end
    end

    assign SERIAL_SHIFT_CLOCK = sc;

    // Pin synchronisers
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            sq_meta <= 16'h0000;
            sq_sync <= 16'h0000;
            half_meta <= 1'b0;
            half_sync <= 1'b0;
        end
        else
        begin
            sq_meta <= SERIAL_DATA_IN;
            sq_sync <= sq_meta;
            half_meta <= SERIAL_HALF_INDICATOR;
            half_sync <= half_meta;                             // R15
        end
    end

    // Register file
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            rd_addr <= 8'h00;
            op <= OP_NONE;
            low_en <= 1'b0;
            high_en <= 1'b0;
            row <= 9'h000;
            col <= 9'h000;
            color <= 16'h0000;
            ser_count <= '0;
            ser_oe <= 1'b0;
            err <= 1'b0;
        end
        else
        begin
            wr_pend <= bus_go && HWRITE;
            if (bus_go)
            begin
                wr_addr <= HADDR[7:0];
                rd_addr <= HADDR[7:0];
            end
            if (cmd_go)
            begin
                op <= new_op;
                low_en <= HWDATA[CMD_LOW_BIT];                  // R3
                high_en <= HWDATA[CMD_HIGH_BIT];
            end
            if (wr_pend && wr_addr == REG_ROW && !busy)
                row <= HWDATA[8:0];
            if (wr_pend && wr_addr == REG_COL && !busy)
                col <= HWDATA[8:0];
            if (wr_pend && wr_addr == REG_COLOR && !busy)
                color <= HWDATA[15:0];
            if (wr_pend && wr_addr == REG_SERIAL)
            begin
                ser_count <= HWDATA[SER_COUNT_LSB +: COUNT_W];
                ser_oe <= HWDATA[SER_OE_BIT];
            end
            else if (sc_rise)
                ser_count <= ser_count - 1'b1;
            if (wr_cmd && refuse)
                err <= 1'b1;                                    // R13 R14
            else if (wr_pend && wr_addr == REG_STATUS && HWDATA[ST_ERR_BIT])
                err <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
            SERIAL_OUTPUT_ENABLE_N <= 1'b1;
        else
            SERIAL_OUTPUT_ENABLE_N <= !ser_oe;                  // R18
    end

    wire [31:0] status_word = {20'h00000, stop_code, 2'h0,
                               (ser_count != '0), err, half_sync,
                               stop_mode, full_done, busy};

    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign HRDATA    =
        (rd_addr == REG_CMD)    ? {27'h0, high_en, low_en, op} :
        (rd_addr == REG_ROW)    ? {23'h0, row} :
        (rd_addr == REG_COL)    ? {23'h0, col} :
        (rd_addr == REG_COLOR)  ? {16'h0, color} :
        (rd_addr == REG_SERIAL) ? {15'h0, ser_oe,
                                   {(16 - COUNT_W){1'b0}}, ser_count} :
        (rd_addr == REG_STATUS) ? status_word :
        (rd_addr == REG_SDATA)  ? {16'h0, sdata} : 32'h0;

    // Checks
    sequence s_row_fall;
        $fell(DRAM_PINS.row_strobe_n);
    endsequence

    sequence s_col_fall;
        $fell(DRAM_PINS.col_strobe_n);
    endsequence

    AST_COLOR_ROW_SEL: assert property (@(posedge CLOCK) disable iff (!RST_N)
        s_row_fall and (op == OP_COLOR) |-> DRAM_PINS.special_function_sel)
        else $error("color load row fall without select"); // R1

    AST_COLOR_COL_SEL: assert property (@(posedge CLOCK) disable iff (!RST_N)
        s_col_fall and (op == OP_COLOR) |-> DRAM_PINS.special_function_sel
        && dq_oe) else $error("color load column fall bad"); // R1

    AST_XFER_START: assert property (@(posedge CLOCK) disable iff (!RST_N)
        s_row_fall and is_xfer |-> !DRAM_PINS.transfer_output_gate_n &&
        DRAM_PINS.low_byte_write_enable_n &&
        DRAM_PINS.high_byte_write_enable_n &&
        (DRAM_PINS.special_function_sel == (op == OP_SPLIT)))
        else $error("transfer start pins wrong"); // R7

    AST_GATE_AFTER_COL: assert property (@(posedge CLOCK) disable iff (!RST_N)
        $rose(DRAM_PINS.transfer_output_gate_n) && is_xfer |->
        !DRAM_PINS.col_strobe_n && !DRAM_PINS.row_strobe_n)
        else $error("gate rose outside strobes"); // R10

    AST_SPLIT_TAP: assert property (@(posedge CLOCK) disable iff (!RST_N)
        $rose(busy) && op == OP_SPLIT |-> !bad_tap)
        else $error("split with invalid tap"); // R13

    AST_SPLIT_AFTER_FULL: assert property (@(posedge CLOCK)
        disable iff (!RST_N)
        $rose(busy) && op == OP_SPLIT |-> full_done)
        else $error("split before full"); // R14

    AST_STOP_SET: assert property (@(posedge CLOCK) disable iff (!RST_N)
        s_row_fall and (op == OP_STOP) |-> !DRAM_PINS.col_strobe_n &&
        !DRAM_PINS.low_byte_write_enable_n &&
        DRAM_PINS.special_function_sel ##[1:12] stop_mode)
        else $error("stop set cycle wrong"); // R22

    AST_OPT_RESET: assert property (@(posedge CLOCK) disable iff (!RST_N)
        ends && op == OP_OPTRST |=> !stop_mode)
        else $error("option reset kept stop mode"); // R24

    AST_SERIAL_HOLD: assert property (@(posedge CLOCK) disable iff (!RST_N)
        busy && $past(busy) |-> !sc)
        else $error("shift clock ran during strobe cycle"); // R17

    AST_SHIFT_COUNT: assert property (@(posedge CLOCK) disable iff (!RST_N)
        sc_rise && !wr_pend |=> ser_count == $past(ser_count) - 1'b1)
        else $error("shift count not advanced"); // R18

endmodule

/* File: src/vcst_pkg.sv */
// Constants, types and register map for the video memory strobe controller
package vcst_pkg;

    // Register byte offsets on the AHB-Lite slave
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_ROW    = 8'h04;
    localparam logic [7:0] REG_COL    = 8'h08;
    localparam logic [7:0] REG_COLOR  = 8'h0C;
    localparam logic [7:0] REG_SERIAL = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_SDATA  = 8'h18;

    // Command register fields
    localparam int CMD_OP_LSB   = 0;
    localparam int CMD_LOW_BIT  = 3;
    localparam int CMD_HIGH_BIT = 4;

    // Operation codes
    localparam logic [2:0] OP_NONE   = 3'h0;
    localparam logic [2:0] OP_COLOR  = 3'h1;
    localparam logic [2:0] OP_FULL   = 3'h2;
    localparam logic [2:0] OP_SPLIT  = 3'h3;
    localparam logic [2:0] OP_STOP   = 3'h4;
    localparam logic [2:0] OP_OPTRST = 3'h5;

    // Serial register fields
    localparam int SER_COUNT_LSB = 0;
    localparam int SER_OE_BIT    = 16;

    // Status register fields
    localparam int ST_BUSY_BIT   = 0;
    localparam int ST_FULL_BIT   = 1;
    localparam int ST_STOP_BIT   = 2;
    localparam int ST_HALF_BIT   = 3;
    localparam int ST_ERR_BIT    = 4;
    localparam int ST_SBUSY_BIT  = 5;
    localparam int ST_CODE_LSB   = 8;

    // Split tap that is never valid within a half
    localparam logic [6:0] TAP_LAST  = 7'h7F;

    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int T_STEP_NS     = 40;
    localparam int T_PRE_NS      = 80;
    localparam int SER_PERIOD_NS = 160;
    localparam int T_STEP_CYC    = (T_STEP_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int T_PRE_CYC     = (T_PRE_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int SER_DIV       = SER_PERIOD_NS / CLK_PERIOD_NS;
    localparam int SER_HALF      = SER_DIV / 2;

    // Memory strobe and control pins
    typedef struct packed {
        logic       row_strobe_n;
        logic       col_strobe_n;
        logic [8:0] addr;
        logic       special_function_sel;
        logic       transfer_output_gate_n;
        logic       low_byte_write_enable_n;
        logic       high_byte_write_enable_n;
    } vcst_pins_type;

    localparam vcst_pins_type PINS_IDLE = '{1'b1, 1'b1, 9'h000, 1'b0,
                                            1'b1, 1'b1, 1'b1};

endpackage
